// [sbs_core.sv]
// Access protocol of a pipelined synchronous burst memory with shared data pins.
// Assumes all strobes, address and write data are synchronous to mclk_i from
// the controller; only the output enable and the mode input arrive asynchronously.
// Overview of operation
// - Strobe low, selected, no write: read
// - Processor strobe ignored while primary select high
// - Capture address into register and counter
// - Read data driven after next edge
// - First cycle after selection: outputs tri-stated
// - Later cycles: output enable decides driving
// - Back-to-back single reads without idle
// - Deselect with strobe floats outputs at once
// - Processor-strobe first cycle ignores write, advance
// - Processor-strobe write completes on second edge
// - Global write writes every lane
// - Byte enable writes only selected lanes
// - Write cycle always turns drivers off
// - Controller strobe write start conditions
// - Controller-strobe write one cycle, no advance
// - Two-bit wraparound counter from low address
// - Order chosen by static mode input
// - Advance low steps counter every edge
// - Interleaved: start XOR beat count
// - Linear: start plus beat modulo four
// - Mode low linear, high interleaved
// - Advance high holds current burst address
// - Each lane select gates its lane in byte writes; global write ignores them
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_core #(
	parameter int ADDR_W = `SBS_ADDR_W,
	parameter int LANES = `SBS_LANES,
	parameter int LANE_W = `SBS_LANE_W
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic proc_addr_strobe_n_i,
	input wire logic ctrl_addr_strobe_n_i,
	input wire logic burst_advance_n_i,
	input wire logic global_write_n_i,
	input wire logic byte_write_en_n_i,
	input wire logic [LANES-1:0] byte_lane_select_n_i,
	input wire logic primary_chip_sel_n_i,
	input wire logic chip_sel2_i,
	input wire logic chip_sel3_n_i,
	input wire logic output_en_n_i,
	input wire logic burst_order_i,
	input wire logic [LANES*LANE_W-1:0] shared_data_lanes_i,
	output logic [LANES*LANE_W-1:0] shared_data_lanes_o,
	output logic [LANES-1:0] shared_data_lanes_oe_o
);
	localparam int DW = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;

	// Refuse sizes the address split and lane slicing cannot serve
	if (ADDR_W < 3 || ADDR_W > 20 || LANES < 1 || LANE_W < 1) begin : g_bad_param
		$error("sbs_core: unsupported parameter values");
	end

	// Output enable and mode arrive asynchronously: two-flop synchronisers
	logic oe_n_s1_q, oe_n_q, mode_s1_q, mode_q;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			oe_n_s1_q <= 1'b1;
			oe_n_q <= 1'b1;
			mode_s1_q <= 1'b1;
			mode_q <= 1'b1;
		end else begin
			oe_n_s1_q <= output_en_n_i;
			oe_n_q <= oe_n_s1_q;
			mode_s1_q <= burst_order_i;
			mode_q <= mode_s1_q;
		end
	end

	// Write-combination decode, used for both strobes
	function automatic logic [LANES-1:0] lane_wr(input logic gw_n, input logic bwe_n,
			input logic [LANES-1:0] sel_n);
		if (!gw_n) begin
			lane_wr = '1;
		end else if (!bwe_n) begin
			lane_wr = ~sel_n;
		end else begin
			lane_wr = '0;
		end
	endfunction

	// Next burst address for the selected order
	function automatic sbs_pkg::sbs_cnt_t burst_next(input sbs_pkg::sbs_cnt_t start,
			input sbs_pkg::sbs_cnt_t beat, input logic interleave);
		sbs_pkg::sbs_cnt_t nb;
		nb = beat + `SBS_BEAT_STEP;
		if (interleave) begin
			burst_next = start ^ nb;
		end else begin
			burst_next = start + nb;
		end
	endfunction

	logic selected, proc_start, ctrl_start, deselect;
	logic [LANES-1:0] wr_lanes;
	assign selected = !primary_chip_sel_n_i && chip_sel2_i && !chip_sel3_n_i;
	assign wr_lanes = lane_wr(global_write_n_i, byte_write_en_n_i, byte_lane_select_n_i);
	// Processor strobe counts only when the primary select is low
	assign proc_start = !proc_addr_strobe_n_i && !primary_chip_sel_n_i && selected;
	// Controller strobe start, read or write; needs processor strobe high
	assign ctrl_start = !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && selected;
	assign deselect = (!ctrl_addr_strobe_n_i && !selected) ||
		(!proc_addr_strobe_n_i && !primary_chip_sel_n_i && !selected);

	sbs_pkg::sbs_cyc_e cyc_q;
	logic [ADDR_W-1:0] addr_q;
	sbs_pkg::sbs_cnt_t start_q, beat_q;
	logic first_q;

	// Access state: reads, two-edge processor writes, one-edge controller writes
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cyc_q <= sbs_pkg::SBS_IDLE;
			first_q <= 1'b0;
		end else if (clk_en_i) begin
			first_q <= 1'b0;
			if (proc_start) begin
				cyc_q <= sbs_pkg::SBS_WR_WAIT;
				first_q <= (cyc_q == sbs_pkg::SBS_IDLE);
			end else if (ctrl_start) begin
				cyc_q <= (|wr_lanes) ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
				first_q <= (cyc_q == sbs_pkg::SBS_IDLE);
			end else if (deselect) begin
				cyc_q <= sbs_pkg::SBS_IDLE;
			end else if (cyc_q != sbs_pkg::SBS_IDLE) begin
				// Continue: write controls decide read or write this edge
				cyc_q <= (|wr_lanes) ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
			end
		end
	end

	// Address register and burst counter
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_q <= '0;
			start_q <= `SBS_CNT_RST;
			beat_q <= `SBS_CNT_RST;
		end else if (clk_en_i) begin
			if (proc_start || ctrl_start) begin
				addr_q <= addr_i;
				start_q <= addr_i[`SBS_BURST_HI:`SBS_BURST_LO];
				beat_q <= `SBS_CNT_RST;
			end else if (cyc_q != sbs_pkg::SBS_IDLE && !deselect && !burst_advance_n_i) begin
				beat_q <= beat_q + `SBS_BEAT_STEP;
			end
			// Advance high: wait cycle, beat held
		end
	end

	// Array address: upper bits as captured, low bits from the counter
	logic [ADDR_W-1:0] cur_addr, wr_addr;
	sbs_pkg::sbs_cnt_t low_now;
	assign low_now = (beat_q == `SBS_CNT_RST) ? start_q :
		burst_next(start_q, beat_q - `SBS_BEAT_STEP, mode_q);
	assign cur_addr = {addr_q[ADDR_W-1:`SBS_BURST_W], low_now};
	// Controller write hits the newly presented address; others the current one
	assign wr_addr = ctrl_start ? addr_i : cur_addr;

	// Memory array with per-lane write; processor-strobe edge never writes
	logic [DW-1:0] rd_word;
	logic write_now;
	assign write_now = clk_en_i && !proc_start && !deselect && (|wr_lanes) &&
		(ctrl_start || cyc_q != sbs_pkg::SBS_IDLE);
	// One array per lane keeps a single writer for each
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [LANE_W-1:0] mem [DEPTH];
		always_ff @(posedge mclk_i) begin
			if (write_now && wr_lanes[l]) begin
				mem[wr_addr] <= shared_data_lanes_i[l*LANE_W +: LANE_W];
			end
		end
		assign rd_word[l*LANE_W +: LANE_W] = mem[cur_addr];
	end

	// Output register loads array data for the following cycle
	logic [DW-1:0] rd_q;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_q <= '0;
		end else if (clk_en_i) begin
			// Captured address reaches the pins one edge after its strobe
			rd_q <= rd_word;
		end
	end
	assign shared_data_lanes_o = rd_q;

	// Drive only in SBS_READ or SBS_WR_WAIT past the first cycle, with output enable low and no write lanes
	logic drive;
	assign drive = (cyc_q == sbs_pkg::SBS_READ || cyc_q == sbs_pkg::SBS_WR_WAIT) &&
		!first_q && !oe_n_q && !(|wr_lanes);
	assign shared_data_lanes_oe_o = {LANES{drive}};

	// Checks
	property p_first_hiz;
		@(posedge mclk_i) disable iff (!nrst_i) first_q |-> !(|shared_data_lanes_oe_o);
	endproperty
	a_first_hiz: assert property (p_first_hiz) else $error("drive in first cycle");

	property p_deselect;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && deselect && !proc_start
			&& !ctrl_start |=> cyc_q == sbs_pkg::SBS_IDLE && !(|shared_data_lanes_oe_o);
	endproperty
	a_deselect: assert property (p_deselect) else $error("no float on deselect");

	property p_wr_off;
		@(posedge mclk_i) disable iff (!nrst_i) (|wr_lanes) |-> !(|shared_data_lanes_oe_o);
	endproperty
	a_wr_off: assert property (p_wr_off) else $error("drive in write");

	property p_oe;
		@(posedge mclk_i) disable iff (!nrst_i) oe_n_q |-> !(|shared_data_lanes_oe_o);
	endproperty
	a_oe: assert property (p_oe) else $error("drive with oe high");

	property p_load;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && (proc_start || ctrl_start)
			|=> addr_q == $past(addr_i) && beat_q == `SBS_CNT_RST;
	endproperty
	a_load: assert property (p_load) else $error("address not captured");

	property p_hold;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && burst_advance_n_i && !proc_start
			&& !ctrl_start |=> $stable(beat_q);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved on wait");

	property p_step;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && !burst_advance_n_i && !proc_start
			&& !ctrl_start && !deselect && cyc_q != sbs_pkg::SBS_IDLE
			|=> beat_q == $past(beat_q) + `SBS_BEAT_STEP;
	endproperty
	a_step: assert property (p_step) else $error("counter did not step");

	property p_upper;
		@(posedge mclk_i) disable iff (!nrst_i) cur_addr[ADDR_W-1:`SBS_BURST_W]
			== addr_q[ADDR_W-1:`SBS_BURST_W];
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits changed");

	property p_proc_nowrite;
		@(posedge mclk_i) disable iff (!nrst_i) proc_start |-> !write_now;
	endproperty
	a_proc_nowrite: assert property (p_proc_nowrite) else $error("write on first edge");

	property p_ign;
		@(posedge mclk_i) disable iff (!nrst_i) primary_chip_sel_n_i |-> !proc_start;
	endproperty
	a_ign: assert property (p_ign) else $error("strobe not ignored");

	// Controller strobe with write lanes writes on its own edge
	property p_ctrl_write;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && ctrl_start && (|wr_lanes)
			|-> write_now;
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("controller write missed");

	// A controller write leaves the machine in the write state
	property p_ctrl_cyc;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && ctrl_start && (|wr_lanes)
			|=> cyc_q == sbs_pkg::SBS_WRITE;
	endproperty
	a_ctrl_cyc: assert property (p_ctrl_cyc) else $error("controller write state wrong");

	// Any start keeps the machine active, so reads can follow at once
	property p_active;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && (proc_start || ctrl_start)
			|=> cyc_q != sbs_pkg::SBS_IDLE;
	endproperty
	a_active: assert property (p_active) else $error("start not taken");

	// Leaving idle marks the first cycle of the access
	property p_first_set;
		@(posedge mclk_i) disable iff (!nrst_i) clk_en_i && (proc_start || ctrl_start)
			&& cyc_q == sbs_pkg::SBS_IDLE |=> first_q;
	endproperty
	a_first_set: assert property (p_first_set) else $error("first cycle not marked");

	// Beat zero presents the captured low address bits
	property p_start_bits;
		@(posedge mclk_i) disable iff (!nrst_i) beat_q == `SBS_CNT_RST
			|-> cur_addr[`SBS_BURST_HI:`SBS_BURST_LO] == start_q;
	endproperty
	a_start_bits: assert property (p_start_bits) else $error("start bits lost");

	// Interleaved order: start XOR beat count
	property p_interleave;
		@(posedge mclk_i) disable iff (!nrst_i) mode_q |-> low_now == (start_q ^ beat_q);
	endproperty
	a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

	// Linear order: start plus beat count, wrapping at four
	property p_linear;
		@(posedge mclk_i) disable iff (!nrst_i) !mode_q
			|-> low_now == sbs_pkg::sbs_cnt_t'(start_q + beat_q);
	endproperty
	a_linear: assert property (p_linear) else $error("linear order wrong");

	// Later read cycle with output enable low drives every lane
	property p_read_drive;
		@(posedge mclk_i) disable iff (!nrst_i) cyc_q == sbs_pkg::SBS_READ && !first_q
			&& !oe_n_q && !(|wr_lanes) |-> &shared_data_lanes_oe_o;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
endmodule

// [sbs_consts.svh]
// Constants for the synchronous burst memory access block.
// Included by sbs_pkg.sv and sbs_core.sv; definitions only.
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_ADDR_W 18
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_BURST_W 2
`define SBS_BURST_LO 0
`define SBS_BURST_HI 1
`define SBS_CNT_RST 2'h0
`define SBS_BEAT_STEP 2'h1
`endif

// [sbs_pkg.sv]
// Types for the synchronous burst memory access block.
// Needs sbs_consts.svh on the include path.
`include "sbs_consts.svh"
package sbs_pkg;
	typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WR_WAIT, SBS_WRITE} sbs_cyc_e;
	typedef logic [`SBS_BURST_W-1:0] sbs_cnt_t;
endpackage

// [sbs_host_model.sv]
// Controller model: drives strobes, address, write controls and write data.
// Assumes the bench calls its tasks; every change lands at a falling edge.
`timescale 1ns/1ps
module sbs_host_model (
	input wire logic mclk_i,
	input wire logic [35:0] rdat_i,
	input wire logic [3:0] doe_i,
	output logic [35:0] wdat_o,
	output logic [17:0] addr_o,
	output logic pas_o,
	output logic cas_o,
	output logic adv_o,
	output logic gw_o,
	output logic bwe_o,
	output logic [3:0] bsel_o,
	output logic oe_n_o,
	output logic due_o
);
	logic [35:0] drv;
	// Wire level: device lanes where it drives, else ours
	always_comb begin
		for (int l = 0; l < 4; l++) begin
			wdat_o[9*l+:9] = doe_i[l] ? rdat_i[9*l+:9] : drv[9*l+:9];
		end
	end
	// Idle levels at time zero
	initial begin
		{pas_o, cas_o, adv_o, gw_o, bwe_o, oe_n_o, due_o} = 7'h7E;
		{addr_o, bsel_o, drv} = {18'h0, 4'hF, 36'h0};
	end
	task cyc;
		@(negedge mclk_i);
	endtask
	// Write; the processor strobe takes controls and data one edge later
	task wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] ln, input logic g, p);
		oe_n_o = 1'b1;
		addr_o = a;
		pas_o = ~p;
		cas_o = p;
		if (p) begin
			{adv_o, gw_o, drv} = {2'h0, ~d};
			cyc;
			{pas_o, adv_o} = 2'h3;
		end
		{gw_o, bwe_o, bsel_o, drv} = {g, 1'b0, ln, d};
		cyc;
		{cas_o, gw_o, bwe_o, bsel_o, drv} = {3'h7, 4'hF, ~d};
	endtask
	// Read: n of 0 gives reads of a then b back to back, else an n-beat burst
	task rd(input logic [17:0] a, b, input int n);
		oe_n_o = 1'b0;
		addr_o = a;
		pas_o = 1'b0;
		cyc;
		addr_o = b;
		pas_o = (n != 0);
		adv_o = (n < 2);
		cyc;
		pas_o = 1'b1;
		for (int k = 0; k < ((n == 0) ? 2 : n); k++) begin
			due_o = 1'b1;
			adv_o = (k + 1 >= n - 1);
			cyc;
		end
		due_o = 1'b0;
	endtask
endmodule

// [test_sbs_core.sv]
// Self-checking bench for the synchronous burst memory access block.
// Assumes the controller model drives every design input but clock, reset, clock enable, burst order and the selects.
`timescale 1ns/1ps
module test_sbs_core;
	logic mclk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ord = 1'b1;
	logic cs_n = 1'b0;
	logic [35:0] rdat, wdat;
	logic [3:0] doe, bsel;
	logic [17:0] addr, a, pa;
	logic pas, cas, burst_advance_n, gw, byte_write_en_n, oe_n, due;
	logic [35:0] mem [int];
	logic [35:0] exp_q [$];
	logic [31:0] lf = 32'h2086;
	int n_mismatch = 0;
	int tests_run = 0;
	always #25 mclk_i = ~mclk_i;
	sbs_host_model hst (.mclk_i(mclk_i), .rdat_i(rdat), .doe_i(doe), .wdat_o(wdat),
		.addr_o(addr), .pas_o(pas), .cas_o(cas), .adv_o(burst_advance_n), .gw_o(gw), .bwe_o(byte_write_en_n),
		.bsel_o(bsel), .oe_n_o(oe_n), .due_o(due));
	sbs_core uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .addr_i(addr),
		.proc_addr_strobe_n_i(pas), .ctrl_addr_strobe_n_i(cas), .burst_advance_n_i(burst_advance_n),
		.global_write_n_i(gw), .byte_write_en_n_i(byte_write_en_n), .byte_lane_select_n_i(bsel),
		.primary_chip_sel_n_i(cs_n), .chip_sel2_i(1'b1), .chip_sel3_n_i(1'b0),
		.output_en_n_i(oe_n), .burst_order_i(ord), .shared_data_lanes_i(wdat),
		.shared_data_lanes_o(rdat), .shared_data_lanes_oe_o(doe));
	function automatic logic [35:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return {lf[3:0], lf};
	endfunction
	task cmp(input string what, input logic [35:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	// Watcher: a flagged edge holds the oldest noted result
	always @(posedge mclk_i) begin
		if (due === 1'b1) begin
			cmp("read data", exp_q.pop_front(), rdat);
			cmp("output enable", 36'hF, {32'h0, doe});
		end
	end
	// Write and keep the reference image in step
	task w(input logic [17:0] wa, input logic [35:0] d, input logic [3:0] ln, input logic g, p);
		logic [35:0] m;
		m = mem.exists(wa) ? mem[wa] : 36'h0;
		for (int l = 0; l < 4; l++) begin
			if (!g || !ln[l]) m[9*l+:9] = d[9*l+:9];
		end
		mem[wa] = m;
		hst.wr(wa, d, ln, g, p);
	endtask
	// Note expected beats, then read
	task r(input logic [17:0] ra, rb, input int n);
		if (n == 0) begin
			exp_q.push_back(mem[ra]);
			exp_q.push_back(mem[rb]);
		end
		for (int k = 0; k < n; k++) begin
			exp_q.push_back(mem[{ra[17:2], ord ? ra[1:0] ^ 2'(k) : ra[1:0] + 2'(k)}]);
		end
		hst.rd(ra, rb, n);
	endtask
	task results;
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		results;
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		@(negedge mclk_i);
		nrst_i = 1'b1;
		// Full writes by the controller strobe, each read back
		for (int i = 0; i < 8; i++) begin
			pa = a;
			a = 18'(rnd());
			w(a, rnd(), 4'hF, 1'b0, 1'b0);
			r(a, a, 1);
		end
		r(pa, a, 0);
		$display("test controller writes done");
		// Processor-strobe writes over every lane pattern, then global
		for (int i = 0; i < 17; i++) begin
			w(a, rnd(), 4'(i), i < 16, 1'b1);
			r(a, a, 1);
		end
		$display("test lane writes done");
		// Bursts in both orders from every start offset
		for (int i = 0; i < 8; i++) begin
			ord = (i < 4);
			a = 18'(rnd());
			for (int j = 0; j < 4; j++) begin
				w({a[17:2], 2'(j)}, rnd(), 4'hF, 1'b0, 1'b0);
			end
			r({a[17:2], 2'(i)}, a, 4);
		end
		$display("test bursts done");
		// Deselected strobes must leave the array untouched
		cs_n = 1'b1;
		hst.wr(a, ~mem[a], 4'hF, 1'b0, 1'b0);
		hst.wr(a, ~mem[a], 4'hF, 1'b0, 1'b1);
		cs_n = 1'b0;
		r(a, a, 1);
		$display("test deselect done");
		results;
	end
endmodule
